// >>> pkg/gpio_map.svh
// register offsets, reset values and bus response codes of one gpio port
// assumes a 32-bit axi4-lite slave with a 12-bit byte address window
//
// Overview of operation
// RULE1 - reset: inputs, software control, debug pins alternate
// RULE2 - data write touches only address-masked bits
// RULE3 - data read returns zero for masked bits
// RULE4 - data register spans 256 word locations
// RULE5 - each pin individually input or output
// RULE6 - direction one drives pin from data
// RULE7 - one combined port interrupt output
// RULE8 - edge interrupt pends until software clears
// RULE9 - level source holds level until recognised
// RULE10 - sense bit: zero edge, one level
// RULE11 - polarity: zero low/falling, one high/rising
// RULE12 - dual-edge bit triggers both edges
// RULE13 - enable bit gates condition to controller
// RULE14 - raw shows all, gated shows enabled
// RULE15 - writing one to clear register clears
// RULE16 - port b pin four enabled sends trigger
// RULE17 - changing sense settings may cause spurious irq
// RULE18 - alternate select hands pin to peripheral
// RULE19 - analog use needs digital controls cleared
// RULE20 - read-only identification registers
// RULE21 - software enables port clock first
// RULE22 - five identical independent port instances
// RULE23 - unconnected bits ignore writes, read meaningless
// RULE24 - eight pins, upper bits read zero
// RULE25 - inputs synchronised; level raw follows pin
`ifndef GPIO_MAP_SVH
`define GPIO_MAP_SVH
`define OFS_DIR 12'h400
`define OFS_SENSE 12'h404
`define OFS_DUAL 12'h408
`define OFS_POL 12'h40C
`define OFS_IEN 12'h410
`define OFS_RAW 12'h414
`define OFS_GATED 12'h418
`define OFS_ICLR 12'h41C
`define OFS_AFSEL 12'h420
`define OFS_DRV2 12'h500
`define OFS_DRV4 12'h504
`define OFS_DRV8 12'h508
`define OFS_ODR 12'h50C
`define OFS_PUR 12'h510
`define OFS_PDR 12'h514
`define OFS_SLR 12'h518
`define OFS_DEN 12'h51C
`define OFS_ID_BASE 12'hFD0
`define OFS_ID0 12'hFE0
`define OFS_ID1 12'hFE4
`define OFS_ID2 12'hFE8
`define OFS_ID3 12'hFEC
`define DATA_REGION_LIMIT 12'h400
`define RST_ZERO 8'h00
`define RST_ONES 8'hFF
`define AXI_OKAY 2'h0
`define AXI_SLVERR 2'h2
`endif

// >>> pkg/gpio_pkg.sv
// types shared by the gpio port
// assumes the map header supplies all numbers
package gpio_pkg;
    // all software-visible per-pin configuration
    typedef struct packed {
        logic [7:0] data;
        logic [7:0] dir;
        logic [7:0] sense;
        logic [7:0] dual;
        logic [7:0] pol;
        logic [7:0] ien;
        logic [7:0] afsel;
        logic [7:0] drv2;
        logic [7:0] drv4;
        logic [7:0] drv8;
        logic [7:0] odr;
        logic [7:0] pur;
        logic [7:0] pdr;
        logic [7:0] slr;
        logic [7:0] den;
    } cfg_t;
    // pad-side bundle towards the pins
    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
    } pad_drive_t;
    // axi write channel phases
    typedef enum logic [1:0] {W_IDLE, W_RESP} wr_phase_t;
    // axi read channel phases
    typedef enum logic [1:0] {R_IDLE, R_DATA} rd_phase_t;
endpackage : gpio_pkg

// >>> rtl/gpio_port.sv
// one eight-pin gpio port with pin interrupts behind an axi4-lite slave
// assumes aclk is the gated peripheral clock; five copies are placed by the chip, see RULE22
//
// Chosen here: the register addresses and register access over AXI4-Lite.
`include "gpio_map.svh"
module gpio_port #(
    parameter logic [7:0] AFSEL_RESET = 8'h00, // debug pins of this copy, see RULE1
    parameter logic [7:0] PIN_PRESENT = 8'hFF, // bonded pads, see RULE23
    parameter bit TRIGGER_PIN_EN = 1'h0, // set on port b only, see RULE16
    parameter int TRIGGER_PIN = 4,
    parameter logic [7:0] ID0 = 8'h5A, // arbitrary identification value
    parameter logic [7:0] ID1 = 8'h3C, // arbitrary identification value
    parameter logic [7:0] ID2 = 8'h11, // arbitrary identification value
    parameter logic [7:0] ID3 = 8'h22 // arbitrary identification value
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address and data
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // pins
    input wire logic [7:0] pin_in,
    output logic [7:0] pin_out,
    output logic [7:0] pin_oe,
    // alternate peripheral side
    input wire logic [7:0] periph_out,
    input wire logic [7:0] periph_oe,
    output logic [7:0] periph_in,
    // pad options
    output logic [7:0] pad_pull_up,
    output logic [7:0] pad_pull_down,
    output logic [7:0] pad_open_drain,
    output logic [7:0] pad_drive_low,
    output logic [7:0] pad_drive_mid,
    output logic [7:0] pad_drive_high,
    output logic [7:0] pad_slew_limit,
    output logic [7:0] pad_digital_en,
    // interrupt and converter trigger
    output logic port_irq,
    output logic converter_trigger
);
    // refuse a trigger pin outside the eight pins of the port
    if (TRIGGER_PIN < 0 || TRIGGER_PIN > 7) begin : g_bad_trigger_pin
        $error("gpio_port: trigger pin out of range");
    end

    // whole state of the port in one struct
    typedef struct packed {
        gpio_pkg::cfg_t cfg; // software registers
        logic [7:0] sync1; // first synchroniser stage
        logic [7:0] sync2; // synchronised pins
        logic [7:0] prev; // last synchronised level
        logic [7:0] edge_pend; // latched edge events
        gpio_pkg::wr_phase_t wph; // write channel
        logic [1:0] bresp;
        gpio_pkg::rd_phase_t rph; // read channel
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [11:0] awaddr_h; // captured write address
        logic aw_got;
        logic [31:0] wdata_h; // captured write data
        logic [3:0] wstrb_h;
        logic w_got;
        logic trig; // registered converter trigger
        logic gate_prev; // gated trigger-pin condition one cycle ago
    } state_t;

    state_t st_r; // registered state
    state_t st_nxt; // next state
    logic [7:0] raw; // raw status
    logic [7:0] lvl_hit; // level condition per pin
    logic [7:0] edge_hit; // edge event this cycle
    logic [7:0] pad_level; // value seen by data reads

    // byte mask from the write strobes; only lane 0 holds data
    function automatic logic [7:0] lane0(input logic [31:0] d, input logic [3:0] s);
        lane0 = s[0] ? d[7:0] : 8'h00;
    endfunction : lane0

    // register readback by offset, ok flag set for mapped words
    function automatic logic [32:0] rd_word(input state_t s, input logic [11:0] a,
                                            input logic [7:0] r, input logic [7:0] lv);
        logic [7:0] v;
        logic ok;
        v = 8'h00;
        ok = 1'b1;
        if (a < `DATA_REGION_LIMIT) begin
            v = lv & a[9:2]; // see RULE3 see RULE4
        end else begin
            case (a)
                `OFS_DIR: v = s.cfg.dir;
                `OFS_SENSE: v = s.cfg.sense;
                `OFS_DUAL: v = s.cfg.dual;
                `OFS_POL: v = s.cfg.pol;
                `OFS_IEN: v = s.cfg.ien;
                `OFS_RAW: v = r; // see RULE14
                `OFS_GATED: v = r & s.cfg.ien; // see RULE14
                `OFS_ICLR: v = 8'h00; // write-only
                `OFS_AFSEL: v = s.cfg.afsel;
                `OFS_DRV2: v = s.cfg.drv2;
                `OFS_DRV4: v = s.cfg.drv4;
                `OFS_DRV8: v = s.cfg.drv8;
                `OFS_ODR: v = s.cfg.odr;
                `OFS_PUR: v = s.cfg.pur;
                `OFS_PDR: v = s.cfg.pdr;
                `OFS_SLR: v = s.cfg.slr;
                `OFS_DEN: v = s.cfg.den;
                // identification words, read only, see RULE20
                `OFS_ID0: v = ID0;
                `OFS_ID1: v = ID1;
                `OFS_ID2: v = ID2;
                `OFS_ID3: v = ID3;
                default: begin
                    ok = (a >= `OFS_ID_BASE) && (a[1:0] == 2'h0); // other id words read zero
                end
            endcase
        end
        rd_word = {ok, 24'h000000, v}; // upper bits zero, see RULE24
    endfunction : rd_word

    // detection: level follows the pin, edges latch until cleared
    // a settings write can still raise a level condition: enables off first, see RULE17
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            lvl_hit[i] = st_r.cfg.pol[i] ? st_r.sync2[i] : ~st_r.sync2[i]; // see RULE11
            if (st_r.cfg.dual[i]) begin
                edge_hit[i] = st_r.sync2[i] ^ st_r.prev[i]; // see RULE12
            end else if (st_r.cfg.pol[i]) begin
                edge_hit[i] = st_r.sync2[i] & ~st_r.prev[i];
            end else begin
                edge_hit[i] = ~st_r.sync2[i] & st_r.prev[i];
            end
        end
        // level-sensitive raw tracks the pin, no latch; see RULE10 see RULE25
        raw = ((st_r.cfg.sense & lvl_hit) | (~st_r.cfg.sense & st_r.edge_pend)) & PIN_PRESENT;
        // outputs read back last written value, inputs the pad, see RULE6
        pad_level = ((st_r.cfg.dir & st_r.cfg.data) | (~st_r.cfg.dir & st_r.sync2)) & PIN_PRESENT;
    end

    // next-state logic: bus slave, register writes, event capture
    always_comb begin
        logic [11:0] wa;
        logic [7:0] wd;
        logic [7:0] clr;
        logic [32:0] rw;
        logic [32:0] wr_chk;
        logic do_wr;
        wa = 12'h000;
        wr_chk = 33'h0;
        wd = 8'h00;
        clr = 8'h00;
        rw = 33'h0;
        do_wr = 1'b0;
        st_nxt = st_r;
        st_nxt.sync1 = pin_in;
        st_nxt.sync2 = st_r.sync1;
        st_nxt.prev = st_r.sync2;
        // take address and data in either order
        if (s_axi_awvalid && !st_r.aw_got && st_r.wph == gpio_pkg::W_IDLE) begin
            st_nxt.awaddr_h = s_axi_awaddr;
            st_nxt.aw_got = 1'b1;
        end
        if (s_axi_wvalid && !st_r.w_got && st_r.wph == gpio_pkg::W_IDLE) begin
            st_nxt.wdata_h = s_axi_wdata;
            st_nxt.wstrb_h = s_axi_wstrb;
            st_nxt.w_got = 1'b1;
        end
        case (st_r.wph)
            gpio_pkg::W_IDLE: begin
                if (st_r.aw_got && st_r.w_got) begin
                    do_wr = 1'b1;
                    wa = {st_r.awaddr_h[11:2], 2'h0};
                    wd = lane0(st_r.wdata_h, st_r.wstrb_h) & PIN_PRESENT; // see RULE23
                    st_nxt.aw_got = 1'b0;
                    st_nxt.w_got = 1'b0;
                    st_nxt.wph = gpio_pkg::W_RESP;
                    st_nxt.bresp = `AXI_OKAY;
                end
            end
            gpio_pkg::W_RESP: begin
                if (s_axi_bready) begin
                    st_nxt.wph = gpio_pkg::W_IDLE;
                end
            end
            default: st_nxt.wph = gpio_pkg::W_IDLE;
        endcase
        // address decode check, shared by both strobe cases
        wr_chk = rd_word(st_r, wa, raw, pad_level);
        // write decode; strobe lane 0 off means the byte is kept
        if (do_wr && st_r.wstrb_h[0]) begin
            if (wa < `DATA_REGION_LIMIT) begin
                // masked update of the data register, see RULE2 see RULE4
                st_nxt.cfg.data = (st_r.cfg.data & ~(wa[9:2] & PIN_PRESENT)) | (wd & wa[9:2]);
            end else begin
                case (wa)
                    `OFS_DIR: st_nxt.cfg.dir = wd; // see RULE5
                    `OFS_SENSE: st_nxt.cfg.sense = wd;
                    `OFS_DUAL: st_nxt.cfg.dual = wd;
                    `OFS_POL: st_nxt.cfg.pol = wd;
                    `OFS_IEN: st_nxt.cfg.ien = wd; // see RULE13
                    `OFS_ICLR: clr = wd; // see RULE15
                    `OFS_AFSEL: st_nxt.cfg.afsel = wd;
                    `OFS_DRV2: st_nxt.cfg.drv2 = wd;
                    `OFS_DRV4: st_nxt.cfg.drv4 = wd;
                    `OFS_DRV8: st_nxt.cfg.drv8 = wd;
                    `OFS_ODR: st_nxt.cfg.odr = wd;
                    `OFS_PUR: st_nxt.cfg.pur = wd;
                    `OFS_PDR: st_nxt.cfg.pdr = wd;
                    `OFS_SLR: st_nxt.cfg.slr = wd;
                    `OFS_DEN: st_nxt.cfg.den = wd;
                    default: st_nxt.bresp = wr_chk[32] ? `AXI_OKAY : `AXI_SLVERR;
                endcase
            end
        end else if (do_wr && !(wa < `DATA_REGION_LIMIT) && !wr_chk[32]) begin
            st_nxt.bresp = `AXI_SLVERR;
        end
        // edges pend until cleared; a new edge beats a clear in the same cycle, see RULE8
        st_nxt.edge_pend = ((st_r.edge_pend & ~clr) | (edge_hit & ~st_r.cfg.sense)) & PIN_PRESENT;
        // read channel, one outstanding read
        case (st_r.rph)
            gpio_pkg::R_IDLE: begin
                if (s_axi_arvalid) begin
                    rw = rd_word(st_r, {s_axi_araddr[11:2], 2'h0}, raw, pad_level);
                    st_nxt.rdata = rw[31:0];
                    st_nxt.rresp = rw[32] ? `AXI_OKAY : `AXI_SLVERR;
                    st_nxt.rph = gpio_pkg::R_DATA;
                end
            end
            gpio_pkg::R_DATA: begin
                if (s_axi_rready) begin
                    st_nxt.rph = gpio_pkg::R_IDLE;
                end
            end
            default: st_nxt.rph = gpio_pkg::R_IDLE;
        endcase
        // one pulse on the rising gated condition of the trigger pin, see RULE16
        // a held level condition must not retrigger, so the last value is kept
        st_nxt.gate_prev = edge_hit_gated(st_r, raw, TRIGGER_PIN);
        st_nxt.trig = TRIGGER_PIN_EN && st_nxt.gate_prev && !st_r.gate_prev;
        // reset values: inputs under software, debug pins alternate, see RULE1
        if (!aresetn) begin
            st_nxt = '0;
            st_nxt.cfg.afsel = AFSEL_RESET;
            st_nxt.cfg.drv2 = `RST_ONES;
            st_nxt.cfg.pur = `RST_ONES;
            st_nxt.cfg.den = `RST_ONES;
            st_nxt.wph = gpio_pkg::W_IDLE;
            st_nxt.rph = gpio_pkg::R_IDLE;
        end
    end

    // gated condition on one pin: pending and enabled
    function automatic logic edge_hit_gated(input state_t s, input logic [7:0] r, input int p);
        edge_hit_gated = r[p[2:0]] & s.cfg.ien[p[2:0]];
    endfunction : edge_hit_gated

    // single state register, synchronous reset folded into st_nxt
    always_ff @(posedge aclk) begin
        st_r <= st_nxt;
    end

    // bus handshakes
    assign s_axi_awready = (st_r.wph == gpio_pkg::W_IDLE) && !st_r.aw_got;
    assign s_axi_wready = (st_r.wph == gpio_pkg::W_IDLE) && !st_r.w_got;
    assign s_axi_bvalid = (st_r.wph == gpio_pkg::W_RESP);
    assign s_axi_bresp = st_r.bresp;
    assign s_axi_arready = (st_r.rph == gpio_pkg::R_IDLE);
    assign s_axi_rvalid = (st_r.rph == gpio_pkg::R_DATA);
    assign s_axi_rdata = st_r.rdata;
    assign s_axi_rresp = st_r.rresp;

    // pin muxing between software and peripheral, see RULE18 see RULE6
    assign pin_out = (st_r.cfg.afsel & periph_out) | (~st_r.cfg.afsel & st_r.cfg.data);
    assign pin_oe = ((st_r.cfg.afsel & periph_oe) | (~st_r.cfg.afsel & st_r.cfg.dir))
                    & PIN_PRESENT;
    assign periph_in = st_r.sync2 & st_r.cfg.den; // digital input only when enabled
    assign pad_pull_up = st_r.cfg.pur;
    assign pad_pull_down = st_r.cfg.pdr;
    assign pad_open_drain = st_r.cfg.odr;
    assign pad_drive_low = st_r.cfg.drv2;
    assign pad_drive_mid = st_r.cfg.drv4;
    assign pad_drive_high = st_r.cfg.drv8;
    assign pad_slew_limit = st_r.cfg.slr;
    assign pad_digital_en = st_r.cfg.den;
    // any enabled pending pin raises the port line, see RULE7 see RULE13
    assign port_irq = |(raw & st_r.cfg.ien);
    assign converter_trigger = st_r.trig;
endmodule : gpio_port

// >>> test/gpio_port_asserts.sv
// bus handshake and pad relations of one gpio port, checked at its ports
// assumes a bind onto every gpio_port copy, one clock, sync active-low reset
module gpio_port_asserts #(
    parameter logic [7:0] AFSEL_RESET = 8'h00 // reset value of alternate select
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // bus handshakes
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // pad side, interrupt and trigger
    input wire logic [7:0] pin_oe,
    input wire logic [7:0] periph_oe,
    input wire logic [7:0] periph_in,
    input wire logic [7:0] pad_digital_en,
    input wire logic port_irq,
    input wire logic converter_trigger
);
    timeunit 1ns;
    timeprecision 1ps;
    // one domain, so clock and disable are given once
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // first edge after release still shows the reset state
    rst_defaults_a: assert property ($past(!aresetn) |-> pin_oe == (AFSEL_RESET & periph_oe)
        && pad_digital_en == 8'hFF && !port_irq) else $error("reset state wrong");
    // write answered two edges after address and data go in together
    wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##2 s_axi_bvalid) else $error("write response late");
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
        && $stable(s_axi_bresp)) else $error("write response dropped");
    bresp_release_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response repeated");
    rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid
        && !s_axi_arready) else $error("read answer late");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
        && $stable(s_axi_rdata)) else $error("read data dropped");
    // a trigger comes only from an enabled pending pin and lasts one cycle
    trig_pulse_a: assert property (converter_trigger |=> !converter_trigger)
        else $error("trigger longer than one cycle");
    trig_cause_a: assert property (converter_trigger |-> $past(port_irq))
        else $error("trigger without interrupt");
    // digital input blocked where digital enable is off
    den_gate_a: assert property ((periph_in & ~pad_digital_en) == 8'h00)
        else $error("input passed with digital enable off");
    cover property (converter_trigger);
    cover property (s_axi_rvalid && s_axi_rready);
    cover property (port_irq && s_axi_bvalid);
endmodule : gpio_port_asserts

bind gpio_port gpio_port_asserts #(.AFSEL_RESET(AFSEL_RESET)) chk (.aclk(aclk),
    .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .pin_oe(pin_oe), .periph_oe(periph_oe),
    .periph_in(periph_in), .pad_digital_en(pad_digital_en), .port_irq(port_irq),
    .converter_trigger(converter_trigger));

// >>> test/pin_model.sv
// pads and alternate peripheral on the far side of a gpio port
// assumes the bench sets the outside level and holds it steady
module pin_model (
    // clock
    input wire logic aclk,
    // port drive and outside source
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe,
    input wire logic [7:0] ext_level,
    // pad level and peripheral output
    output logic [7:0] pin_in,
    output logic [7:0] periph_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // the port wins where it drives, the outside source elsewhere
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
    // pattern moves every cycle so a stale select shows at once
    logic [7:0] pattern = 8'h00; // peripheral output pattern, single driver
    always @(posedge aclk) pattern <= pattern + 8'h35;
    assign periph_out = pattern;
endmodule : pin_model

// >>> test/tb_top.sv
// self-checking bench of one gpio port set up as port b
// assumes the map header and the pin model; axi master tasks drive the bus
`include "gpio_map.svh"
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin failures++; $display("BAD %s exp %h got %h", n, e, g); end end
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk = 1'h0, aresetn = 1'h0;
    logic [11:0] awaddr = 12'h000, araddr = 12'h000;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic [31:0] wdata = 32'h0, rdata;
    logic [7:0] ext_level = 8'h00, periph_oe = 8'h00, pin_in, pin_out, pin_oe, periph_out;
    logic [1:0] bresp, rresp;
    logic awready, wready, bvalid, arready, rvalid, port_irq, converter_trigger;
    int failures = 0, checks = 0, cycles = 0, trig_n = 0;
    // the port clock runs from time zero, before any access
    always #4 aclk = ~aclk;
    gpio_port #(.AFSEL_RESET(8'h80), .TRIGGER_PIN_EN(1'h1)) uut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .periph_out(periph_out),
        .periph_oe(periph_oe), .periph_in(), .pad_pull_up(), .pad_pull_down(),
        .pad_open_drain(), .pad_drive_low(), .pad_drive_mid(), .pad_drive_high(),
        .pad_slew_limit(), .pad_digital_en(), .port_irq(port_irq),
        .converter_trigger(converter_trigger));
    pin_model far (.aclk(aclk), .pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext_level),
        .pin_in(pin_in), .periph_out(periph_out));
    // trigger pulses counted so a missing or doubled pulse shows
    always @(posedge aclk) if (converter_trigger === 1'h1) trig_n++;
    task automatic end_of_test();
        $display("failures %0d checks %0d", failures, checks);
        if (failures == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : end_of_test
    // a hung handshake ends the run as a mismatch
    always @(posedge aclk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            end_of_test();
        end
    end
    // write: address and data offered together, each dropped when taken
    task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
        logic a_done;
        logic d_done;
        a_done = 1'h0;
        d_done = 1'h0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= {24'hA5A5A5, d};
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        // local flags: the valids just assigned are not yet visible in this step
        while (!(a_done && d_done)) begin
            @(posedge aclk);
            if (!a_done && awready === 1'h1) begin
                awvalid <= 1'h0;
                a_done = 1'h1;
            end
            if (!d_done && wready === 1'h1) begin
                wvalid <= 1'h0;
                d_done = 1'h1;
            end
        end
        do @(posedge aclk); while (bvalid !== 1'h1);
        bready <= 1'h0;
        `CHK("bresp", er, bresp)
    endtask : wr
    // read and compare the whole word, upper bits must be zero
    task automatic rdx(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do @(posedge aclk); while (arready !== 1'h1);
        arvalid <= 1'h0;
        do @(posedge aclk); while (rvalid !== 1'h1);
        rready <= 1'h0;
        `CHK("rdata", e, rdata)
        `CHK("rresp", er, rresp)
    endtask : rdx
    // pending expected from {sense, dual, pol}, start and end levels
    function automatic logic pend_of(input logic [2:0] m, input logic s, input logic e);
        return m[2] ? (e == m[0]) : ((s != e) && (m[1] || e == m[0]));
    endfunction : pend_of
    logic [11:0] rst_a [10] = '{`OFS_DIR, `OFS_SENSE, `OFS_IEN, `OFS_AFSEL, `OFS_DRV2,
        `OFS_DRV4, `OFS_PUR, `OFS_PDR, `OFS_DEN, `OFS_ID0};
    logic [7:0] rst_v [10] = '{8'h00, 8'h00, 8'h00, 8'h80, 8'hFF, 8'h00, 8'hFF, 8'h00, 8'hFF,
        8'h5A};
    // {sense, dual, pol, start, end}: rise, fall, wrong edge, both, levels
    logic [4:0] modes [8] = '{5'h05, 5'h02, 5'h06, 5'h09, 5'h0E, 5'h15, 5'h12, 5'h16};
    logic [7:0] cur, wd, mk;
    logic p;
    int t0;
    initial begin
        void'($urandom(87));
        repeat (2) @(posedge aclk);
        aresetn <= 1'h1;
        foreach (rst_a[i]) rdx(rst_a[i], {24'h0, rst_v[i]}, `AXI_OKAY);
        wr(12'h600, 8'hFF, `AXI_SLVERR);
        rdx(12'h600, 32'h0, `AXI_SLVERR);
        wr(`OFS_DIR, 8'hFF, `AXI_OKAY);
        cur = 8'h00;
        for (int i = 0; i < 12; i++) begin
            wd = (i == 0) ? 8'hEB : 8'($urandom);
            mk = (i == 0) ? 8'h26 : 8'($urandom);
            periph_oe <= 8'($urandom);
            wr({2'h0, mk, 2'h0}, wd, `AXI_OKAY);
            cur = (cur & ~mk) | (wd & mk);
            mk = (i == 0) ? 8'h31 : 8'($urandom);
            rdx({2'h0, mk, 2'h0}, {24'h0, cur & mk}, `AXI_OKAY);
            @(negedge aclk);
            `CHK("pin_out", cur & 8'h7F, pin_out & 8'h7F)
            `CHK("alt_out", periph_out[7], pin_out[7])
            `CHK("pin_oe", {periph_oe[7], 7'h7F}, pin_oe)
        end
        wr(`OFS_DIR, 8'h00, `AXI_OKAY);
        wr(`OFS_AFSEL, 8'h00, `AXI_OKAY);
        ext_level <= 8'($urandom);
        repeat (4) @(posedge aclk);
        rdx(12'h3FC, {24'h0, ext_level}, `AXI_OKAY);
        `CHK("pin_oe", 8'h00, pin_oe)
        foreach (modes[i]) begin
            p = pend_of(modes[i][4:2], modes[i][1], modes[i][0]);
            wr(`OFS_IEN, 8'h00, `AXI_OKAY);
            wr(`OFS_SENSE, {3'h0, modes[i][4], 4'h0}, `AXI_OKAY);
            wr(`OFS_DUAL, {3'h0, modes[i][3], 4'h0}, `AXI_OKAY);
            wr(`OFS_POL, {3'h0, modes[i][2], 4'h0}, `AXI_OKAY);
            ext_level <= {3'h0, modes[i][1], 4'h0};
            repeat (6) @(posedge aclk);
            wr(`OFS_ICLR, 8'hFF, `AXI_OKAY);
            ext_level <= {3'h0, modes[i][0], 4'h0};
            repeat (6) @(posedge aclk);
            wr(`OFS_ICLR, 8'hEF, `AXI_OKAY);
            rdx(`OFS_RAW, {27'h0, p, 4'h0}, `AXI_OKAY);
            rdx(`OFS_GATED, 32'h0, `AXI_OKAY);
            `CHK("irq_off", 1'h0, port_irq)
            t0 = trig_n;
            wr(`OFS_IEN, 8'h10, `AXI_OKAY);
            rdx(`OFS_GATED, {27'h0, p, 4'h0}, `AXI_OKAY);
            `CHK("irq", p, port_irq)
            `CHK("trig", 32'(p), 32'(trig_n - t0))
            wr(`OFS_ICLR, 8'h10, `AXI_OKAY);
            rdx(`OFS_RAW, {27'h0, p & modes[i][4], 4'h0}, `AXI_OKAY);
        end
        end_of_test();
    end
endmodule : tb_top
